// *** hw/ctc_top.sv ***
// Chopper timing core with AXI4-Lite configuration access
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ctc_top (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [3:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [3:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_cur_reached,
	input wire logic i_neg_nominal,
	output ctc_pkg::ctc_bridge_t o_bridge,
	output logic signed [5:0] o_hyst,
	output logic signed [5:0] o_sine_ofs
);
	import ctc_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [9:0] blank_len(input logic [1:0] sel);
		case (sel)
			2'h0: blank_len = CTC_BLANK_0;
			2'h1: blank_len = CTC_BLANK_1;
			2'h2: blank_len = CTC_BLANK_2;
			default: blank_len = CTC_BLANK_3;
		endcase
	endfunction : blank_len

	function automatic logic signed [5:0] end_val(input logic [3:0] c);
		end_val = $signed({2'h0, c}) - CTC_HYST_END_VAL_BIAS;
	endfunction : end_val

	// ------------------------------------------------------------------
	// Reset release and input synchronisers
	// ------------------------------------------------------------------
	logic rst_s1_r;
	logic rst_n_r;
	logic [1:0] cmp_s1_r;
	logic [1:0] cmp_s2_r;

	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cmp_s1_r <= 2'h0;
			cmp_s2_r <= 2'h0;
		end else begin
			cmp_s1_r <= {i_neg_nominal, i_cur_reached};
			cmp_s2_r <= cmp_s1_r;
		end
	end

	wire logic cur_hit = cmp_s2_r[0];
	wire logic neg_hit = cmp_s2_r[1];

	// ------------------------------------------------------------------
	// AXI4-Lite write channel
	// ------------------------------------------------------------------
	ctc_cfg_t cfg_r;
	logic aw_have_r;
	logic w_have_r;
	logic [3:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;

	wire logic aw_take = i_awvalid && o_awready;
	wire logic w_take = i_wvalid && o_wready;
	wire logic do_write = aw_have_r && w_have_r && !o_bvalid;
	wire logic cfg_hit = (aw_addr_r == CTC_OFS_CFG) && (&w_strb_r[2:0])
		&& (w_data_r[19:17] == CTC_CFG_SELECT);

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= 4'h0;
			o_awready <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_have_r <= 1'b1;
				aw_addr_r <= i_awaddr;
			end else if (do_write) begin
				aw_have_r <= 1'b0;
			end
			o_awready <= !aw_take && (!aw_have_r || do_write);
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			w_have_r <= 1'b0;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			o_wready <= 1'b0;
		end else begin
			if (w_take) begin
				w_have_r <= 1'b1;
				w_data_r <= i_wdata;
				w_strb_r <= i_wstrb;
			end else if (do_write) begin
				w_have_r <= 1'b0;
			end
			o_wready <= !w_take && (!w_have_r || do_write);
		end
	end

	// Configuration store; words without the select pattern are refused
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			cfg_r <= CTC_CFG_RESET;
		end else if (do_write && cfg_hit) begin
			cfg_r <= ctc_cfg_t'(w_data_r[19:0]);
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_bvalid <= 1'b0;
			o_bresp <= CTC_RESP_OKAY;
		end else if (do_write) begin
			o_bvalid <= 1'b1;
			o_bresp <= cfg_hit ? CTC_RESP_OKAY : CTC_RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Chopper state
	// ------------------------------------------------------------------
	ctc_state_t st_r;
	logic [9:0] tmr_r;
	logic [9:0] blank_r;
	logic [6:0] dec_r;
	logic signed [5:0] hyst_r;
	logic [3:0] rnd;

	ctc_lfsr u_lfsr (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n_r),
		.o_rnd(rnd)
	);

	wire logic [3:0] fast_code = {cfg_r.hyst_decr_sel[0],
		cfg_r.hyst_start_val};
	wire logic [9:0] fast_len = 10'(fast_code * CTC_FAST_UNIT);
	wire logic [9:0] slow_fix = 10'(CTC_SLOW_BASE
		+ cfg_r.off_time * CTC_SLOW_UNIT);
	wire logic [9:0] slow_len = cfg_r.random_off_en
		? 10'(slow_fix + {6'h0, rnd} - CTC_RND_BIAS) : slow_fix;
	wire logic blank_done = (blank_r == 10'h0);
	wire logic chop_off = (cfg_r.off_time == 4'h0);
	wire logic const_mode = cfg_r.chop_algo_sel;
	wire logic fast_cmp_end = !cfg_r.hyst_decr_sel[1]
		&& blank_done && neg_hit;
	wire logic [6:0] dec_len = 7'((cfg_r.hyst_decr_sel + 7'h1)
		* CTC_DECR_UNIT);
	wire logic signed [5:0] hyst_end = end_val(cfg_r.hyst_end_val);
	wire logic signed [5:0] hyst_top = hyst_end
		+ $signed({3'h0, cfg_r.hyst_start_val}) + 6'sh01;
	wire logic cycle_start = (st_r == CTC_ST_SLOW && tmr_r == 10'h0)
		|| (st_r == CTC_ST_OFF && !chop_off);

	// Phase sequencing
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			st_r <= CTC_ST_OFF;
			tmr_r <= 10'h0;
		end else if (chop_off) begin
			st_r <= CTC_ST_OFF;
			tmr_r <= 10'h0;
		end else begin
			case (st_r)
				CTC_ST_OFF: begin
					st_r <= CTC_ST_ON;
				end
				CTC_ST_ON: begin
					if (blank_done && cur_hit) begin
						if (const_mode && fast_len != 10'h0) begin
							st_r <= CTC_ST_FAST;
							tmr_r <= fast_len - 10'h1;
						end else begin
							st_r <= CTC_ST_SLOW;
							tmr_r <= slow_len - 10'h1;
						end
					end
				end
				CTC_ST_FAST: begin
					if (tmr_r == 10'h0 || fast_cmp_end) begin
						st_r <= CTC_ST_SLOW;
						tmr_r <= slow_len - 10'h1;
					end else begin
						tmr_r <= tmr_r - 10'h1;
					end
				end
				CTC_ST_SLOW: begin
					if (tmr_r == 10'h0) begin
						st_r <= CTC_ST_ON;
					end else begin
						tmr_r <= tmr_r - 10'h1;
					end
				end
				default: begin
					st_r <= CTC_ST_OFF;
				end
			endcase
		end
	end

	// Blanking restarts on each switching event into on or fast decay
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			blank_r <= 10'h0;
		end else if (cycle_start || (st_r == CTC_ST_ON && blank_done
			&& cur_hit && const_mode)) begin
			blank_r <= blank_len(cfg_r.blank_time_sel) - 10'h1;
		end else if (!blank_done) begin
			blank_r <= blank_r - 10'h1;
		end
	end

	// Hysteresis ramp from start+end down to end
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			hyst_r <= 6'sh00;
			dec_r <= 7'h0;
		end else if (cycle_start) begin
			hyst_r <= hyst_top;
			dec_r <= dec_len - 7'h1;
		end else if (dec_r == 7'h0) begin
			dec_r <= dec_len - 7'h1;
			if (hyst_r > hyst_end) begin
				hyst_r <= hyst_r - 6'sh01;
			end else begin
				hyst_r <= hyst_end;
			end
		end else begin
			dec_r <= dec_r - 7'h1;
		end
	end

	// ------------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_bridge <= '0;
		end else begin
			o_bridge.drv_en <= !chop_off && st_r != CTC_ST_OFF;
			o_bridge.on_phase <= !chop_off && st_r == CTC_ST_ON;
			o_bridge.fast_decay <= !chop_off && st_r == CTC_ST_FAST;
			o_bridge.slow_decay <= !chop_off && st_r == CTC_ST_SLOW;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_hyst <= 6'sh00;
			o_sine_ofs <= 6'sh00;
		end else begin
			o_hyst <= const_mode ? 6'sh00 : hyst_r;
			o_sine_ofs <= const_mode ? hyst_end : 6'sh00;
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read channel
	// ------------------------------------------------------------------
	wire logic ar_take = i_arvalid && o_arready;

	always_ff @(posedge i_ref_clk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0;
			o_rresp <= CTC_RESP_OKAY;
		end else begin
			o_arready <= !ar_take && !(o_rvalid && !i_rready);
			if (ar_take) begin
				o_rvalid <= 1'b1;
				o_rresp <= CTC_RESP_OKAY;
				case (i_araddr)
					CTC_OFS_CFG: o_rdata <= {12'h0, cfg_r};
					CTC_OFS_STAT: o_rdata <= {21'h0, hyst_r,
						o_bridge.drv_en, 2'(st_r), 2'h0};
					default: begin
						o_rdata <= 32'h0;
						o_rresp <= CTC_RESP_SLVERR;
					end
				endcase
			end else if (i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

endmodule : ctc_top
`default_nettype wire

// *** hw/ctc_pkg.sv ***
// Package: constants, field layout and types of the chopper timing block
// Behaviour
// - Data bits 19..17 = 100 select chopper config
// - Blank code selects 16, 24, 36, 54 clocks
// - Bit 14 picks hysteresis or constant off-time
// - Constant off-time: fast decay follows on; stops at negative current
// - Bit 13 randomly modulates slow decay length
// - Hysteresis decrement period 16, 32, 48, 64
// - Bit 12 set: only timer ends fast decay
// - End code maps to hysteresis -3..12
// - Constant off-time: end code is sine offset
// - Start offset equals start code plus one
// - Fast decay lasts 32 clocks per unit
// - Off-time zero disables driver, bridges off
// - Slow decay lasts 24 plus 32 times code
package ctc_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [3:0] CTC_OFS_CFG = 4'h0;
	localparam logic [3:0] CTC_OFS_STAT = 4'h4;
	localparam logic [2:0] CTC_CFG_SELECT = 3'h4;
	localparam logic [19:0] CTC_CFG_RESET = 20'h80000;
	localparam logic [1:0] CTC_RESP_OKAY = 2'h0;
	localparam logic [1:0] CTC_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// Timing counts, in system clocks, and hysteresis end bias
	// ------------------------------------------------------------------
	localparam logic [9:0] CTC_BLANK_0 = 10'h010;
	localparam logic [9:0] CTC_BLANK_1 = 10'h018;
	localparam logic [9:0] CTC_BLANK_2 = 10'h024;
	localparam logic [9:0] CTC_BLANK_3 = 10'h036;
	localparam logic [6:0] CTC_DECR_UNIT = 7'h10;
	localparam logic [9:0] CTC_FAST_UNIT = 10'h020;
	localparam logic [9:0] CTC_SLOW_BASE = 10'h018;
	localparam logic [9:0] CTC_SLOW_UNIT = 10'h020;
	localparam logic [9:0] CTC_RND_BIAS = 10'h00C;
	localparam logic signed [5:0] CTC_HYST_END_VAL_BIAS = 6'sh03;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] reg_sel;
		logic [1:0] blank_time_sel;
		logic chop_algo_sel;
		logic random_off_en;
		logic [1:0] hyst_decr_sel;
		logic [3:0] hyst_end_val;
		logic [2:0] hyst_start_val;
		logic [3:0] off_time;
	} ctc_cfg_t;

	typedef struct packed {
		logic drv_en;
		logic on_phase;
		logic fast_decay;
		logic slow_decay;
	} ctc_bridge_t;

	typedef enum logic [1:0] {
		CTC_ST_OFF,
		CTC_ST_ON,
		CTC_ST_FAST,
		CTC_ST_SLOW
	} ctc_state_t;

endpackage : ctc_pkg

// *** hw/ctc_lfsr.sv ***
// Pseudo-random source for off-time modulation
`timescale 1ns/100ps
`default_nettype none
module ctc_lfsr (
	input wire logic i_clk,
	input wire logic i_rst_n,
	output logic [3:0] o_rnd
);
	import ctc_pkg::*;

	logic [15:0] lfsr_r;

	// Maximal-length 16-bit sequence, free running
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lfsr_r <= 16'hACE1;
		end else begin
			lfsr_r <= {lfsr_r[14:0],
				lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rnd <= 4'h0;
		end else begin
			o_rnd <= lfsr_r[3:0];
		end
	end

endmodule : ctc_lfsr
`default_nettype wire

// *** test/ctc_properties.sv ***
// Checker of bus handshakes and bridge phases of the chopper block
`timescale 1ns/100ps
`default_nettype none
module ctc_properties (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic [1:0] o_bresp,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire ctc_pkg::ctc_bridge_t o_bridge,
	input wire logic signed [5:0] o_hyst,
	input wire logic signed [5:0] o_sine_ofs
);
	import ctc_pkg::*;
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// ----------------------------------------------------------------
	// Bus
	// ----------------------------------------------------------------
	bresp_hold_a: assert property (o_bvalid && !i_bready |=>
		o_bvalid && $stable(o_bresp)) else $error("bresp dropped");
	rdata_hold_a: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata)) else $error("rdata dropped");
	read_answer_a: assert property (i_arvalid && o_arready |=>
		o_rvalid) else $error("read answer late");
	write_answer_a: assert property (i_awvalid && o_awready &&
		i_wvalid && o_wready |-> ##[1:2] o_bvalid)
		else $error("write answer late");
	aw_block_a: assert property (i_awvalid && o_awready |=>
		!o_awready) else $error("address taken twice in a row");
	// ----------------------------------------------------------------
	// Bridge and mode outputs
	// ----------------------------------------------------------------
	drv_off_a: assert property (!o_bridge.drv_en |->
		o_bridge[2:0] == 3'h0) else $error("bridge on while disabled");
	phase_hot_a: assert property ($onehot0(o_bridge[2:0]))
		else $error("two phases at once");
	blank_min_a: assert property ($rose(o_bridge.on_phase) |=>
		(o_bridge.on_phase || !o_bridge.drv_en) [*8])
		else $error("on phase cut short");
	slow_min_a: assert property ($rose(o_bridge.slow_decay) |=>
		(o_bridge.slow_decay || !o_bridge.drv_en) [*8])
		else $error("slow phase cut short");
	mode_excl_a: assert property (o_hyst == 6'sh00 ||
		o_sine_ofs == 6'sh00) else $error("both modes reported");
	ofs_range_a: assert property (o_sine_ofs >= -6'sh03 &&
		o_sine_ofs <= 6'sh0C) else $error("offset out of range");
endmodule : ctc_properties
bind ctc_top ctc_properties u_prop (.*);
`default_nettype wire

// *** test/ctc_top_tb_top.sv ***
// Self-checking testbench of the chopper timing block
`timescale 1ns/100ps
`default_nettype none
module ctc_top_tb_top;
	import ctc_pkg::*;
	logic i_ref_clk = 0, i_rst_n = 0, i_awvalid = 0, i_wvalid = 0;
	logic i_bready = 0, i_arvalid = 0, i_rready = 0;
	logic i_cur_reached = 0, i_neg_nominal = 0;
	logic [3:0] i_awaddr = 0, i_wstrb = 0, i_araddr = 0;
	logic [31:0] i_wdata = 0, o_rdata;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp;
	ctc_bridge_t o_bridge;
	logic signed [5:0] o_hyst, o_sine_ofs;
	int bad_count = 0, comparisons = 0, n;
	int bl[4] = '{16, 24, 36, 54};
	typedef struct packed {
		logic [3:0] a; logic [31:0] d; logic [3:0] s;
		logic [1:0] r; logic [31:0] c;
	} ctc_row_t;
	ctc_row_t rows[5] = '{
		'{4'h0, 32'h89AA3, 4'h7, 2'h0, 32'h89AA3},
		'{4'h0, 32'h29AA3, 4'hF, 2'h2, 32'h89AA3},
		'{4'h0, 32'h80001, 4'h3, 2'h2, 32'h89AA3},
		'{4'h4, 32'h80001, 4'hF, 2'h2, 32'h89AA3},
		'{4'h0, 32'hFFF87FFF, 4'hF, 2'h0, 32'h87FFF}};
	ctc_top uut (.*);
	always #25 i_ref_clk = ~i_ref_clk;
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task chk(string nm, logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task test_done;
		$display("bad_count %0d comparisons %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : test_done
	task wr(logic [3:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] r);
		logic dn;
		dn = 0;
		@(posedge i_ref_clk);
		i_awaddr <= a;
		i_wdata <= d;
		i_wstrb <= s;
		i_awvalid <= 1;
		i_wvalid <= 1;
		i_bready <= 1;
		while (!dn) begin
			@(posedge i_ref_clk);
			if (i_awvalid && o_awready) i_awvalid <= 0;
			if (i_wvalid && o_wready) i_wvalid <= 0;
			if (i_bready && o_bvalid) begin
				dn = 1;
				i_bready <= 0;
				chk("bresp", 32'(o_bresp), 32'(r));
			end
		end
	endtask : wr
	task rd(logic [3:0] a, logic [31:0] d, logic [1:0] r);
		logic dn;
		dn = 0;
		@(posedge i_ref_clk);
		i_araddr <= a;
		i_arvalid <= 1;
		i_rready <= 1;
		while (!dn) begin
			@(posedge i_ref_clk);
			if (i_arvalid && o_arready) i_arvalid <= 0;
			if (i_rready && o_rvalid) begin
				dn = 1;
				i_rready <= 0;
				chk("rdata", o_rdata, d);
				chk("rresp", 32'(o_rresp), 32'(r));
			end
		end
	endtask : rd
	task meas(int b, output int len);
		len = 0;
		@(posedge i_ref_clk);
		while (o_bridge[b] === 1'b1) @(posedge i_ref_clk);
		while (o_bridge[b] !== 1'b1) @(posedge i_ref_clk);
		while (o_bridge[b] === 1'b1) begin
			len++;
			@(posedge i_ref_clk);
		end
	endtask : meas
	function logic [31:0] cw(logic [1:0] b, logic m, logic [1:0] h,
		logic [2:0] st, logic [3:0] t);
		return {12'h0, 3'h4, b, m, 1'b0, h, 4'h0, st, t};
	endfunction : cw
	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge i_ref_clk);
		i_rst_n <= 1;
		repeat (3) @(posedge i_ref_clk);
		chk("bridge", 32'(o_bridge), 0);
		rd(4'h0, 32'h80000, CTC_RESP_OKAY);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d, rows[i].s, rows[i].r);
			rd(4'h0, rows[i].c, CTC_RESP_OKAY);
		end
		rd(4'hC, 0, CTC_RESP_SLVERR);
		i_cur_reached <= 1;
		for (int k = 0; k < 4; k++) begin
			wr(4'h0, cw(k[1:0], 0, 2'h0, 3'h0, 4'(k + 2)), 4'hF, 0);
			meas(2, n);
			chk("on_len", n, bl[k]);
			meas(0, n);
			chk("slow_len", n, 24 + 32 * (k + 2));
		end
		wr(4'h0, cw(2'h1, 0, 2'h0, 3'h0, 4'h1), 4'hF, 0);
		meas(0, n);
		chk("slow_one", n, 56);
		wr(4'h0, cw(2'h0, 0, 2'h0, 3'h0, 4'h2) | 32'h2000, 4'hF, 0);
		meas(0, n);
		chk("slow_rnd", 32'(n >= 76 && n <= 91), 1);
		wr(4'h0, cw(2'h0, 0, 2'h1, 3'h2, 4'h2) | 32'h280, 4'hF, 0);
		@(posedge i_ref_clk);
		while (o_bridge.on_phase === 1'b1) @(posedge i_ref_clk);
		while (o_bridge.on_phase !== 1'b1) @(posedge i_ref_clk);
		chk("hyst_top", 32'(o_hyst), 5);
		chk("drv_en", 32'(o_bridge.drv_en), 1);
		repeat (32) @(posedge i_ref_clk);
		chk("hyst_step", 32'(o_hyst), 4);
		repeat (64) @(posedge i_ref_clk);
		chk("hyst_end", 32'(o_hyst), 2);
		wr(4'h0, cw(2'h0, 1, 2'h0, 3'h3, 4'h1 ^ 4'h3), 4'hF, 0);
		meas(1, n);
		chk("fast_len", n, 96);
		chk("sine_ofs", 32'(o_sine_ofs), -32'sd3);
		wr(4'h0, cw(2'h0, 1, 2'h1, 3'h3, 4'h2), 4'hF, 0);
		meas(1, n);
		chk("fast_msb", n, 352);
		i_neg_nominal <= 1;
		wr(4'h0, cw(2'h0, 1, 2'h2, 3'h3, 4'h2), 4'hF, 0);
		meas(1, n);
		chk("fast_timer", n, 96);
		wr(4'h0, cw(2'h0, 1, 2'h0, 3'h3, 4'h2), 4'hF, 0);
		meas(1, n);
		chk("fast_early", n, bl[0]);
		wr(4'h0, cw(2'h0, 1, 2'h0, 3'h3, 4'h0), 4'hF, 0);
		repeat (3) @(posedge i_ref_clk);
		chk("bridge_off", 32'(o_bridge), 0);
		repeat (64) @(posedge i_ref_clk);
		rd(4'h4, 32'h7A0, CTC_RESP_OKAY);
		i_rst_n <= 0;
		@(posedge i_ref_clk);
		i_rst_n <= 1;
		repeat (3) @(posedge i_ref_clk);
		rd(4'h0, 32'h80000, CTC_RESP_OKAY);
		test_done;
	end
	initial begin
		#(50 * 20000);
		bad_count++;
		test_done;
	end
endmodule : ctc_top_tb_top
`default_nettype wire
